// >>> src/csl_status_leds.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module csl_status_leds #(
  parameter int unsigned LINK_HALF_CYC = csl_pkg::LINK_HALF_CYC,
  parameter int unsigned BLINK_ON_CYC = csl_pkg::BLINK_ON_CYC,
  parameter int unsigned BLINK_OFF_CYC = csl_pkg::BLINK_OFF_CYC,
  parameter int unsigned FLASH_ON_CYC = csl_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_CYC = csl_pkg::FLASH_OFF_CYC,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Card status inputs.
  input wire logic board_link_setup,
  input wire logic board_link_up,
  input wire logic wireless_online,
  input wire logic [1:0] node_state,
  input wire logic card_fault,
  input wire logic bus_off,
  input wire logic inverter_fault,
  input wire logic addr_invalid,
  input wire logic rx_error,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Indicators and interrupt.
  output logic board_link_indicator,
  output logic wireless_link_indicator,
  output logic run_indicator,
  output logic error_indicator,
  output logic irq
);
  import csl_pkg::*;

  typedef struct packed {
    csl_mode_t board_mode;
    csl_mode_t run_mode;
    csl_mode_t err_mode;
    logic board_led;
    logic wl_led;
    logic run_led;
    logic err_led;
    logic [1:0] ctrl;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic [EVT_W-2:0] prev_level;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } csl_top_state_t;

  // Turns a display mode and the two pattern generators into a lamp level.
  function automatic logic mode_lit(input csl_mode_t mode, input logic blink, input logic flash);
    logic lit;
    lit = 1'b0;
    case (mode)
      CSL_MODE_OFF:
      begin
        lit = 1'b0;
      end
      CSL_MODE_ON:
      begin
        lit = 1'b1;
      end
      CSL_MODE_BLINK:
      begin
        lit = blink;
      end
      CSL_MODE_FLASH:
      begin
        lit = flash;
      end
      default:
      begin
        lit = 1'b0;
      end
    endcase
    return lit;
  endfunction

  // Compares an aligned word address against a register offset.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    return addr == ADDR_W'(offset);
  endfunction

  csl_top_state_t cur;
  csl_top_state_t next_cur;

  logic link_pat;
  logic run_blink_pat;
  logic run_flash_pat;
  logic err_blink_pat;
  logic err_flash_pat;
  logic board_restart;
  logic run_blink_restart;
  logic run_flash_restart;
  logic err_blink_restart;
  logic err_flash_restart;
  logic [EVT_W-2:0] level_now;
  logic [EVT_W-1:0] events;
  logic enabled;
  logic lamp_test;

  // Board-link blink with equal lit and dark halves.
  csl_blink_gen #(
    .ON_CYC(LINK_HALF_CYC),
    .OFF_CYC(LINK_HALF_CYC)
  ) u_link_gen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(board_restart),
    .pattern(link_pat)
  );

  // Run indicator repeating blink.
  csl_blink_gen #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC)
  ) u_run_blink (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(run_blink_restart),
    .pattern(run_blink_pat)
  );

  // Run indicator single flash.
  csl_blink_gen #(
    .ON_CYC(FLASH_ON_CYC),
    .OFF_CYC(FLASH_OFF_CYC)
  ) u_run_flash (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(run_flash_restart),
    .pattern(run_flash_pat)
  );

  // Error indicator repeating blink.
  csl_blink_gen #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC)
  ) u_err_blink (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(err_blink_restart),
    .pattern(err_blink_pat)
  );

  // Error indicator single flash.
  csl_blink_gen #(
    .ON_CYC(FLASH_ON_CYC),
    .OFF_CYC(FLASH_OFF_CYC)
  ) u_err_flash (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .restart(err_flash_restart),
    .pattern(err_flash_pat)
  );

  // Each pattern restarts with a lit phase when its indicator enters that mode.
  assign board_restart = (next_cur.board_mode == CSL_MODE_BLINK) && (cur.board_mode != CSL_MODE_BLINK);
  assign run_blink_restart = (next_cur.run_mode == CSL_MODE_BLINK) && (cur.run_mode != CSL_MODE_BLINK);
  assign run_flash_restart = (next_cur.run_mode == CSL_MODE_FLASH) && (cur.run_mode != CSL_MODE_FLASH);
  assign err_blink_restart = (next_cur.err_mode == CSL_MODE_BLINK) && (cur.err_mode != CSL_MODE_BLINK);
  assign err_flash_restart = (next_cur.err_mode == CSL_MODE_FLASH) && (cur.err_mode != CSL_MODE_FLASH);

  assign level_now = {card_fault, rx_error, addr_invalid, inverter_fault, bus_off, wireless_online, board_link_up};
  assign enabled = cur.ctrl[CTRL_EN_BIT];
  assign lamp_test = cur.ctrl[CTRL_TEST_BIT];

  always_comb
  begin
    next_cur = cur;
    events = '0;

    // Board-link indicator mode.
    if (board_link_setup)
    begin
      next_cur.board_mode = CSL_MODE_ON;
    end
    else if (board_link_up)
    begin
      next_cur.board_mode = CSL_MODE_BLINK;
    end
    else
    begin
      next_cur.board_mode = CSL_MODE_OFF;
    end

    // Run indicator mode; a fault overrides every node state.
    if (card_fault)
    begin
      next_cur.run_mode = CSL_MODE_OFF;
    end
    else
    begin
      case (node_state)
        NODE_OPER:
        begin
          next_cur.run_mode = CSL_MODE_ON;
        end
        NODE_PREOP:
        begin
          next_cur.run_mode = CSL_MODE_BLINK;
        end
        NODE_STOP:
        begin
          next_cur.run_mode = CSL_MODE_FLASH;
        end
        default:
        begin
          next_cur.run_mode = CSL_MODE_OFF;
        end
      endcase
    end

    // Error indicator mode, highest priority first.
    if (bus_off || inverter_fault)
    begin
      next_cur.err_mode = CSL_MODE_ON;
    end
    else if (addr_invalid)
    begin
      next_cur.err_mode = CSL_MODE_BLINK;
    end
    else if (rx_error)
    begin
      next_cur.err_mode = CSL_MODE_FLASH;
    end
    else
    begin
      next_cur.err_mode = CSL_MODE_OFF;
    end

    // Lamp levels from the registered modes and the pattern generators; the wireless lamp follows wireless_online.
    if (lamp_test)
    begin
      next_cur.board_led = 1'b1;
      next_cur.wl_led = 1'b1;
      next_cur.run_led = 1'b1;
      next_cur.err_led = 1'b1;
    end
    else if (!enabled)
    begin
      next_cur.board_led = 1'b0;
      next_cur.wl_led = 1'b0;
      next_cur.run_led = 1'b0;
      next_cur.err_led = 1'b0;
    end
    else
    begin
      next_cur.board_led = mode_lit(cur.board_mode, link_pat, 1'b0);
      next_cur.wl_led = wireless_online;
      next_cur.run_led = mode_lit(cur.run_mode, run_blink_pat, run_flash_pat);
      next_cur.err_led = mode_lit(cur.err_mode, err_blink_pat, err_flash_pat);
    end

    // Events are rising edges of the seven status inputs in level_now (not board_link_setup or node_state), plus loss of the board link.
    events[EVT_W-2:0] = level_now & ~cur.prev_level;
    events[EVT_LINK_LOST] = cur.prev_level[EVT_LINK_UP] && !board_link_up;
    next_cur.prev_level = level_now;

    // Register reads; data stand only in the cycle after the strobe.
    next_cur.rdata = '0;
    if (reg_rd)
    begin
      if (hit(reg_addr, REG_CTRL))
      begin
        next_cur.rdata = DATA_W'(cur.ctrl);
      end
      else if (hit(reg_addr, REG_STATE))
      begin
        next_cur.rdata = DATA_W'({node_state, level_now});
      end
      else if (hit(reg_addr, REG_IRQ_STATUS))
      begin
        next_cur.rdata = DATA_W'(cur.irq_status);
      end
      else if (hit(reg_addr, REG_IRQ_MASK))
      begin
        next_cur.rdata = DATA_W'(cur.irq_mask);
      end
      else if (hit(reg_addr, REG_MODE))
      begin
        next_cur.rdata = DATA_W'({cur.err_mode, cur.run_mode, cur.board_mode});
      end
      else
      begin
        next_cur.rdata = '0;
      end
    end

    // A read of the status clears it, but an event in the same cycle still sets.
    if (reg_rd && hit(reg_addr, REG_IRQ_STATUS))
    begin
      next_cur.irq_status = events;
    end
    else
    begin
      next_cur.irq_status = cur.irq_status | events;
    end

    // Register writes.
    if (reg_wr)
    begin
      if (hit(reg_addr, REG_CTRL))
      begin
        next_cur.ctrl = reg_wdata[1:0];
      end
      else if (hit(reg_addr, REG_IRQ_MASK))
      begin
        next_cur.irq_mask = reg_wdata[EVT_W-1:0];
      end
    end

    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur.board_mode <= CSL_MODE_OFF;
      cur.run_mode <= CSL_MODE_OFF;
      cur.err_mode <= CSL_MODE_OFF;
      cur.board_led <= 1'b0;
      cur.wl_led <= 1'b0;
      cur.run_led <= 1'b0;
      cur.err_led <= 1'b0;
      cur.ctrl <= CTRL_RESET;
      cur.irq_status <= '0;
      cur.irq_mask <= IRQ_MASK_RESET;
      cur.prev_level <= '0;
      cur.irq <= 1'b0;
      cur.rdata <= '0;
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign board_link_indicator = cur.board_led;
  assign wireless_link_indicator = cur.wl_led;
  assign run_indicator = cur.run_led;
  assign error_indicator = cur.err_led;
  assign irq = cur.irq;

endmodule

// >>> common/csl_pkg.sv
package csl_pkg;

  // Clock rate of the card clock.
  localparam longint unsigned CLK_HZ = 200_000_000;

  // Converts a time in milliseconds to whole clock cycles, rounded up, at least one.
  function automatic int unsigned ms_to_cyc(input longint unsigned ms);
    longint unsigned cyc;
    cyc = (ms * CLK_HZ + 64'd999) / 64'd1000;
    if (cyc == 64'd0)
    begin
      cyc = 64'd1;
    end
    return int'(cyc[31:0]);
  endfunction

  // Board-link blink: 1 s period, lit 0.5 s and dark 0.5 s.
  localparam longint unsigned LINK_PERIOD_MS = 1000;
  localparam longint unsigned LINK_HALF_MS = LINK_PERIOD_MS / 2;
  localparam int unsigned LINK_HALF_CYC = ms_to_cyc(LINK_HALF_MS);

  // Repeating blink of the run and error indicators.
  localparam longint unsigned BLINK_ON_MS = 200;
  localparam longint unsigned BLINK_OFF_MS = 200;
  localparam int unsigned BLINK_ON_CYC = ms_to_cyc(BLINK_ON_MS);
  localparam int unsigned BLINK_OFF_CYC = ms_to_cyc(BLINK_OFF_MS);

  // Single flash: one short lit phase, then a long dark phase.
  localparam longint unsigned FLASH_ON_MS = 200;
  localparam longint unsigned FLASH_OFF_MS = 1000;
  localparam int unsigned FLASH_ON_CYC = ms_to_cyc(FLASH_ON_MS);
  localparam int unsigned FLASH_OFF_CYC = ms_to_cyc(FLASH_OFF_MS);

  // Fieldbus node state codes on the node_state input.
  localparam logic [1:0] NODE_INIT = 2'h0;
  localparam logic [1:0] NODE_PREOP = 2'h1;
  localparam logic [1:0] NODE_OPER = 2'h2;
  localparam logic [1:0] NODE_STOP = 2'h3;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_MODE = 8'h10;

  // Control fields and reset values.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // Event bit positions in the interrupt status and mask registers.
  localparam int EVT_LINK_UP = 0;
  localparam int EVT_WL_ONLINE = 1;
  localparam int EVT_BUS_OFF = 2;
  localparam int EVT_INV_FAULT = 3;
  localparam int EVT_ADDR_BAD = 4;
  localparam int EVT_RX_ERR = 5;
  localparam int EVT_CARD_FAULT = 6;
  localparam int EVT_LINK_LOST = 7;
  localparam int EVT_W = 8;

  // Indicator display modes, one-hot.
  typedef enum logic [3:0] {
    CSL_MODE_OFF = 4'b0001,
    CSL_MODE_ON = 4'b0010,
    CSL_MODE_BLINK = 4'b0100,
    CSL_MODE_FLASH = 4'b1000
  } csl_mode_t;

endpackage

// >>> src/csl_blink_gen.sv
`timescale 1ns/10ps
module csl_blink_gen #(
  parameter int unsigned ON_CYC = 1,
  parameter int unsigned OFF_CYC = 1,
  parameter int CNT_W = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pattern control.
  input wire logic restart,
  output logic pattern
);
  import csl_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic lit;
  } csl_gen_state_t;

  localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(ON_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYC - 1);

  csl_gen_state_t cur;
  csl_gen_state_t next_cur;

  // Lit phase first, then dark phase, repeating; restart begins a fresh lit phase.
  always_comb
  begin
    next_cur = cur;
    if (restart)
    begin
      next_cur.cnt = '0;
      next_cur.lit = 1'b1;
    end
    else if ((cur.lit && cur.cnt == ON_LAST) || (!cur.lit && cur.cnt == OFF_LAST))
    begin
      next_cur.cnt = '0;
      next_cur.lit = !cur.lit;
    end
    else
    begin
      next_cur.cnt = cur.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '{cnt: '0, lit: 1'b1};
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

  assign pattern = cur.lit;

endmodule

// >>> tb/csl_status_leds_assertions.sv
`timescale 1ns/10ps
module csl_status_leds_assertions
  import csl_pkg::*;
#(
  parameter int unsigned LINK_HALF_CYC = 10,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register writes.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // Card status.
  input wire logic board_link_setup,
  input wire logic board_link_up,
  input wire logic wireless_online,
  input wire logic [1:0] node_state,
  input wire logic card_fault,
  input wire logic bus_off,
  input wire logic inverter_fault,
  input wire logic addr_invalid,
  input wire logic rx_error,
  // Indicators.
  input wire logic board_link_indicator,
  input wire logic wireless_link_indicator,
  input wire logic run_indicator,
  input wire logic error_indicator
);
  logic [31:0] up_len;
  logic [31:0] run_len;
  logic last;
  logic [1:0] ctrl_sh;
  logic plain;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Shadows the control register so that lamp test and disable are not taken for faults.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_sh <= CTRL_RESET;
    end
    else if (clk_en && reg_wr && reg_addr == ADDR_W'(REG_CTRL))
    begin
      ctrl_sh <= reg_wdata[1:0];
    end
  end

  assign plain = ctrl_sh[CTRL_EN_BIT] && !ctrl_sh[CTRL_TEST_BIT];

  // Measures how long the board lamp has held its level.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      up_len <= 32'h0;
      run_len <= 32'h0;
      last <= 1'h0;
    end
    else
    begin
      last <= board_link_indicator;
      run_len <= (board_link_indicator != last) ? 32'h1 : run_len + 32'h1;
      up_len <= (board_link_up && !board_link_setup && clk_en && plain) ? up_len + 32'h1 : 32'h0;
    end
  end

  chk_setup_lamp_on: assert property ((board_link_setup && clk_en && plain)[*3] |-> board_link_indicator)
    else $error("board lamp not lit during setup");
  chk_link_half_period: assert property ((up_len > 3 * LINK_HALF_CYC && board_link_indicator != last)
    |-> run_len == LINK_HALF_CYC) else $error("board lamp phase length wrong");
  chk_link_lost_off: assert property ((!board_link_setup && !board_link_up && clk_en && plain)[*3]
    |-> !board_link_indicator) else $error("board lamp lit while disconnected");
  chk_wireless_follow: assert property (clk_en && plain ##1 1'h1
    |-> wireless_link_indicator == $past(wireless_online)) else $error("wireless lamp wrong");
  chk_run_oper_on: assert property ((node_state == NODE_OPER && !card_fault && clk_en && plain)[*3]
    |-> run_indicator) else $error("run lamp not lit when operational");
  chk_run_fault_off: assert property ((card_fault && clk_en && plain)[*3] |-> !run_indicator)
    else $error("run lamp lit on fault");
  chk_err_steady_on: assert property (((bus_off || inverter_fault) && clk_en && plain)[*3]
    |-> error_indicator) else $error("error lamp not lit");
  chk_err_quiet_off: assert property ((!bus_off && !inverter_fault && !addr_invalid && !rx_error
    && clk_en && plain)[*3] |-> !error_indicator) else $error("error lamp lit without error");
  chk_lamp_test_lit: assert property ((clk_en && ctrl_sh[CTRL_TEST_BIT])[*2]
    |-> board_link_indicator && wireless_link_indicator && run_indicator && error_indicator)
    else $error("lamp test not lighting all lamps");
endmodule

bind csl_status_leds csl_status_leds_assertions #(.LINK_HALF_CYC(LINK_HALF_CYC), .ADDR_W(ADDR_W),
  .DATA_W(DATA_W)) chk_inst (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .board_link_setup(board_link_setup),
  .board_link_up(board_link_up),
  .wireless_online(wireless_online),
  .node_state(node_state),
  .card_fault(card_fault),
  .bus_off(bus_off),
  .inverter_fault(inverter_fault),
  .addr_invalid(addr_invalid),
  .rx_error(rx_error),
  .board_link_indicator(board_link_indicator),
  .wireless_link_indicator(wireless_link_indicator),
  .run_indicator(run_indicator),
  .error_indicator(error_indicator)
);

// >>> tb/csl_far_model.sv
`timescale 1ns/10ps
module csl_far_model (
  // Clock.
  input wire logic sys_clk,
  // Board, wireless and fieldbus status.
  output logic board_link_setup,
  output logic board_link_up,
  output logic wireless_online,
  output logic [1:0] node_state,
  output logic card_fault,
  output logic bus_off,
  output logic inverter_fault,
  output logic addr_invalid,
  output logic rx_error
);
  initial
  begin
    {board_link_setup, board_link_up, wireless_online, node_state} = 5'h0;
    {card_fault, bus_off, inverter_fault, addr_invalid, rx_error} = 5'h0;
  end

  // Bits from top: setup, up, online, node state, fault, bus-off, inverter, address, receive.
  task drive(input logic [9:0] v);
    @(posedge sys_clk);
    {board_link_setup, board_link_up, wireless_online, node_state, card_fault, bus_off, inverter_fault,
      addr_invalid, rx_error} <= v;
  endtask
endmodule

// >>> tb/csl_status_leds_bench.sv
`timescale 1ns/10ps
module csl_status_leds_bench;
  import csl_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic setup, up, wl, cf, bo, inv, ai, rx, lb, lw, lr, le, irq;
  logic [1:0] ns;
  int n_errors;
  int checked;

  csl_far_model far (.sys_clk(sys_clk), .board_link_setup(setup), .board_link_up(up),
    .wireless_online(wl), .node_state(ns), .card_fault(cf), .bus_off(bo), .inverter_fault(inv),
    .addr_invalid(ai), .rx_error(rx));

  csl_status_leds #(.LINK_HALF_CYC(10), .BLINK_ON_CYC(4), .BLINK_OFF_CYC(4), .FLASH_ON_CYC(3),
    .FLASH_OFF_CYC(12)) csl_status_leds_inst (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .board_link_setup(setup), .board_link_up(up), .wireless_online(wl), .node_state(ns),
    .card_fault(cf), .bus_off(bo), .inverter_fault(inv), .addr_invalid(ai), .rx_error(rx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .board_link_indicator(lb), .wireless_link_indicator(lw),
    .run_indicator(lr), .error_indicator(le), .irq(irq));

  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task tick;
    @(posedge sys_clk);
    #1;
  endtask

  task chk(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  function automatic logic lamp(input int s);
    case (s)
      0: return lb;
      1: return lr;
      2: return le;
      default: return lw;
    endcase
  endfunction

  task steady(input int s, input logic v, input string m);
    int n;
    n = 0;
    repeat (4) tick;
    repeat (20)
    begin
      tick;
      if (lamp(s) !== v)
        n++;
    end
    chk(n == 0, m);
  endtask

  // Waits for a fresh lit phase, then times one lit and one dark phase.
  task meas(input int s, input int on_c, input int off_c, input string m);
    int n;
    int k;
    k = 0;
    while (lamp(s) !== 1'h0 && k < 99)
    begin
      tick;
      k++;
    end
    while (lamp(s) !== 1'h1 && k < 99)
    begin
      tick;
      k++;
    end
    n = 0;
    while (lamp(s) === 1'h1 && n < 99)
    begin
      n++;
      tick;
    end
    chk(n == on_c, m);
    n = 0;
    while (lamp(s) === 1'h0 && n < 99)
    begin
      n++;
      tick;
    end
    chk(n == off_c, m);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  task t_board;
    far.drive(10'h200);
    steady(0, 1'h1, "setup lamp");
    far.drive(10'h100);
    meas(0, 10, 10, "link blink");
    far.drive(10'h180);
    tick;
    tick;
    chk(lw === 1'h1, "wireless on");
    far.drive(10'h000);
    steady(0, 1'h0, "link off");
    chk(lw === 1'h0, "wireless off");
    $display("test board done");
  endtask

  task t_run;
    far.drive(10'h040);
    steady(1, 1'h1, "run oper");
    far.drive(10'h020);
    meas(1, 4, 4, "run preop");
    far.drive(10'h060);
    meas(1, 3, 12, "run stop");
    far.drive(10'h050);
    steady(1, 1'h0, "run fault");
    $display("test run done");
  endtask

  task t_err;
    far.drive(10'h00b);
    steady(2, 1'h1, "err busoff");
    far.drive(10'h007);
    steady(2, 1'h1, "err inverter");
    far.drive(10'h003);
    meas(2, 4, 4, "err addr");
    far.drive(10'h001);
    meas(2, 3, 12, "err rx");
    far.drive(10'h040);
    steady(2, 1'h0, "err quiet");
    $display("test error done");
  endtask

  task t_regs;
    far.drive(10'h000);
    wr(REG_IRQ_MASK, 32'h4);
    rd(REG_IRQ_STATUS);
    far.drive(10'h008);
    repeat (3) tick;
    chk(irq === 1'h1, "irq set");
    rd(REG_STATE);
    chk(d === 32'h4, "state");
    rd(REG_MODE);
    chk(d === 32'h211, "mode");
    rd(REG_IRQ_STATUS);
    chk(d[2] === 1'h1, "status");
    chk(irq === 1'h0, "irq clear");
    wr(REG_IRQ_MASK, 32'h0);
    far.drive(10'h000);
    far.drive(10'h008);
    repeat (3) tick;
    chk(irq === 1'h0, "irq masked");
    rd(8'h14);
    chk(d === 32'h0, "unmapped");
    $display("test registers done");
  endtask

  task t_ctrl;
    far.drive(10'h000);
    wr(REG_CTRL, 32'h3);
    steady(1, 1'h1, "lamp test");
    chk(lb === 1'h1 && lw === 1'h1 && le === 1'h1, "lamp test all");
    far.drive(10'h240);
    wr(REG_CTRL, 32'h0);
    steady(0, 1'h0, "disabled");
    chk(lr === 1'h0 && lw === 1'h0 && le === 1'h0, "disabled all");
    rd(REG_CTRL);
    chk(d === 32'h0, "ctrl read");
    wr(REG_CTRL, 32'h1);
    steady(1, 1'h1, "enabled again");
    @(posedge sys_clk);
    clk_en <= 1'h0;
    far.drive(10'h250);
    repeat (6) tick;
    chk(lr === 1'h1, "frozen");
    @(posedge sys_clk);
    clk_en <= 1'h1;
    repeat (3) tick;
    chk(lr === 1'h0, "unfrozen fault");
    $display("test control done");
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'h1;
    t_board;
    t_run;
    t_err;
    t_regs;
    t_ctrl;
    print_verdict;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    print_verdict;
  end
endmodule
